/* File: rtl/rmsi_top.sv */
// msi configuration registers and issue of error interrupt writes
`timescale 1ns/100ps
`include "rmsi_cfg.svh"

module rmsi_top #(
    parameter bit         CFG_IMPL        = 1'b1,
    parameter bit         FAULT_IMPL      = 1'b1,
    parameter bit         RECOV_IMPL      = 1'b1,
    parameter bit         STD_LAYOUT      = 1'b1,
    parameter bit         EN_DISABLE      = 1'b1,
    parameter bit         NS_CONFIG       = 1'b1,
    parameter bit         NS_WRITE_OK     = 1'b0,
    parameter bit         NS_RESET        = 1'b0,
    parameter bit         NS_FIXED        = 1'b0,
    parameter bit         SHR_CONFIG      = 1'b1,
    parameter logic [1:0] SHR_FIXED       = 2'h2,
    parameter bit         MT_CONFIG       = 1'b1,
    parameter logic [3:0] MT_FIXED        = 4'h0,
    parameter int         PA_BITS         = 48
) (
    input  wire logic                REF_CLK,
    input  wire logic                RESETN,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    input  wire logic [11:0]         REG_ADDR,
    input  wire logic [31:0]         REG_WDATA,
    input  wire logic                REG_NS,
    output logic [31:0]              REG_RDATA,
    output logic                     REG_RDVALID,
    input  wire logic                FAULT_IRQ,
    input  wire logic                RECOVERY_IRQ,
    input  wire logic                MSI_READY,
    output logic                     MSI_VALID,
    output logic [63:0]              MSI_ADDR,
    output logic [31:0]              MSI_DATA,
    output logic                     MSI_NS,
    output logic [1:0]               MSI_SHR,
    output logic [3:0]               MSI_MEMTYPE
);
    import rmsi_pkg::*;

    // register groups exist only under these build options
    // a custom layout keeps the recommended fields: a legal own choice
    localparam bit FAULT_ON = CFG_IMPL &&
                              (FAULT_IMPL || !STD_LAYOUT);
    localparam bit RECOV_ON = CFG_IMPL &&
                              (RECOV_IMPL || !STD_LAYOUT);

    // keeps bits 55:2 up to the physical address width, rest zero
    function automatic logic [63:0] addr_mask(input logic [63:0] v);
        logic [63:0] m;
        m = 64'h0;
        for (int i = `RMSI_ADDR_LOW; i <= `RMSI_ADDR_TOP; i++) begin
            if (i < PA_BITS) begin
                m[i] = 1'b1;
            end
        end
        addr_mask = v & m;
    endfunction

    // device types and non-cacheable normal are always outer shareable
    function automatic logic [1:0] eff_shr(input logic [1:0] shr,
                                           input logic [3:0] mt);
        if (mt[3:2] == `RMSI_DEV_CLASS || mt == `RMSI_MT_NORMAL_NC) begin
            eff_shr = `RMSI_SHR_OUTER;
        end else begin
            eff_shr = shr;
        end
    endfunction

    logic [63:0] fault_addr_ff,  nxt_fault_addr;
    logic [31:0] fault_data_ff,  nxt_fault_data;
    logic [63:0] recov_addr_ff,  nxt_recov_addr;
    logic [31:0] recov_data_ff,  nxt_recov_data;
    logic        en_ff,          nxt_en;
    logic        ns_ff,          nxt_ns;
    logic [1:0]  shr_ff,         nxt_shr;
    logic [3:0]  mt_ff,          nxt_mt;
    logic [31:0] rdata_ff,       nxt_rdata;
    logic        rdvalid_ff,     nxt_rdvalid;
    logic [31:0] ctrl_view;
    logic        en_eff;
    logic        ns_eff;
    logic [1:0]  shr_sel;
    logic [3:0]  mt_eff;
    logic        ctrl_wr_ok;
    rmsi_attr_type msi_attr;

    rmsi_if link ();

    // effective control fields, fixed choices where not configurable
    always_comb begin
        en_eff = EN_DISABLE ? en_ff : 1'b1;
        if (NS_WRITE_OK) begin
            ns_eff = 1'b1;
        end else if (NS_CONFIG) begin
            ns_eff = ns_ff;
        end else begin
            ns_eff = NS_FIXED;
        end
        shr_sel = SHR_CONFIG ? shr_ff : SHR_FIXED;
        mt_eff = MT_CONFIG ? mt_ff : MT_FIXED;
    end

    // control word as software sees it; absent fields read zero
    always_comb begin
        ctrl_view = 32'h0;
        if (RECOV_ON) begin
            ctrl_view[`RMSI_EN_BIT] = EN_DISABLE & en_ff;
            ctrl_view[`RMSI_NS_BIT] = NS_CONFIG & !NS_WRITE_OK & ns_ff;
            if (SHR_CONFIG) begin
                ctrl_view[`RMSI_SHR_HI:`RMSI_SHR_LO] = shr_ff;
            end
            if (MT_CONFIG) begin
                ctrl_view[`RMSI_MT_HI:`RMSI_MT_LO] = mt_ff;
            end
        end
    end

    // secure-only control word drops non-secure writes
    assign ctrl_wr_ok = RECOV_ON && (NS_WRITE_OK || !REG_NS);

    // register write decode; absent groups keep their values
    always_comb begin
        nxt_fault_addr = fault_addr_ff;
        nxt_fault_data = fault_data_ff;
        nxt_recov_addr = recov_addr_ff;
        nxt_recov_data = recov_data_ff;
        nxt_en         = en_ff;
        nxt_ns         = ns_ff;
        nxt_shr        = shr_ff;
        nxt_mt         = mt_ff;
        if (REG_WR) begin
            case (REG_ADDR)
                `RMSI_OFF_FAULT_ADDR_LO: begin
                    if (FAULT_ON) begin
                        nxt_fault_addr = addr_mask(
                            {fault_addr_ff[63:32], REG_WDATA});
                    end
                end
                `RMSI_OFF_FAULT_ADDR_HI: begin
                    if (FAULT_ON) begin
                        nxt_fault_addr = addr_mask(
                            {REG_WDATA, fault_addr_ff[31:0]});
                    end
                end
                `RMSI_OFF_FAULT_DATA: begin
                    if (FAULT_ON) begin
                        nxt_fault_data = REG_WDATA;
                    end
                end
                `RMSI_OFF_RECOV_ADDR_LO: begin
                    if (RECOV_ON) begin
                        nxt_recov_addr = addr_mask(
                            {recov_addr_ff[63:32], REG_WDATA});
                    end
                end
                `RMSI_OFF_RECOV_ADDR_HI: begin
                    if (RECOV_ON) begin
                        nxt_recov_addr = addr_mask(
                            {REG_WDATA, recov_addr_ff[31:0]});
                    end
                end
                `RMSI_OFF_RECOV_DATA: begin
                    if (RECOV_ON) begin
                        nxt_recov_data = REG_WDATA;
                    end
                end
                `RMSI_OFF_RECOV_CTRL: begin
                    if (ctrl_wr_ok) begin
                        if (EN_DISABLE) begin
                            nxt_en = REG_WDATA[`RMSI_EN_BIT];
                        end
                        if (NS_CONFIG && !NS_WRITE_OK) begin
                            nxt_ns = REG_WDATA[`RMSI_NS_BIT];
                        end
                        if (SHR_CONFIG) begin
                            nxt_shr = REG_WDATA[`RMSI_SHR_HI:`RMSI_SHR_LO];
                        end
                        if (MT_CONFIG) begin
                            nxt_mt = REG_WDATA[`RMSI_MT_HI:`RMSI_MT_LO];
                        end
                    end
                end
                default: begin
                    nxt_en = en_ff;
                end
            endcase
        end
    end

    // read decode, answered one cycle after the strobe; unmapped reads 0
    always_comb begin
        nxt_rdvalid = REG_RD;
        nxt_rdata   = 32'h0;
        if (REG_RD) begin
            case (REG_ADDR)
                `RMSI_OFF_FAULT_ADDR_LO:
                    nxt_rdata = FAULT_ON ? fault_addr_ff[31:0] : 32'h0;
                `RMSI_OFF_FAULT_ADDR_HI:
                    nxt_rdata = FAULT_ON ? fault_addr_ff[63:32] : 32'h0;
                `RMSI_OFF_FAULT_DATA:
                    nxt_rdata = FAULT_ON ? fault_data_ff : 32'h0;
                `RMSI_OFF_RECOV_ADDR_LO:
                    nxt_rdata = RECOV_ON ? recov_addr_ff[31:0] : 32'h0;
                `RMSI_OFF_RECOV_ADDR_HI:
                    nxt_rdata = RECOV_ON ? recov_addr_ff[63:32] : 32'h0;
                `RMSI_OFF_RECOV_DATA:
                    nxt_rdata = RECOV_ON ? recov_data_ff : 32'h0;
                `RMSI_OFF_RECOV_CTRL:
                    nxt_rdata = ctrl_view;
                default:
                    nxt_rdata = 32'h0;
            endcase
        end
    end

    // config registers; payloads and attributes cleared only so that
    // simulation starts clean, software must still program them
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            fault_addr_ff <= 64'h0;
            fault_data_ff <= 32'h0;
            recov_addr_ff <= 64'h0;
            recov_data_ff <= 32'h0;
            en_ff         <= `RMSI_EN_RESET;
            ns_ff         <= NS_RESET;
            shr_ff        <= `RMSI_SHR_NONE;
            mt_ff         <= `RMSI_MT_DEV_NGNRNE;
            rdata_ff      <= 32'h0;
            rdvalid_ff    <= 1'b0;
        end else begin
            fault_addr_ff <= nxt_fault_addr;
            fault_data_ff <= nxt_fault_data;
            recov_addr_ff <= nxt_recov_addr;
            recov_data_ff <= nxt_recov_data;
            en_ff         <= nxt_en;
            ns_ff         <= nxt_ns;
            shr_ff        <= nxt_shr;
            mt_ff         <= nxt_mt;
            rdata_ff      <= nxt_rdata;
            rdvalid_ff    <= nxt_rdvalid;
        end
    end

    // events to the sequencer; a disabled recovery event is dropped
    assign link.fault_evt     = FAULT_IRQ & FAULT_ON;
    assign link.recov_evt     = RECOVERY_IRQ & RECOV_ON & en_eff;
    assign link.fault_addr    = fault_addr_ff;
    assign link.fault_data    = fault_data_ff;
    assign link.recov_addr    = recov_addr_ff;
    assign link.recov_data    = recov_data_ff;
    // fault control word lives elsewhere; its writes use fixed attributes
    assign link.fault_attr.ns = NS_FIXED | NS_WRITE_OK;
    assign link.fault_attr.shr = eff_shr(SHR_FIXED, MT_FIXED);
    assign link.fault_attr.mt = MT_FIXED;
    assign link.recov_attr.ns = ns_eff;
    assign link.recov_attr.shr = eff_shr(shr_sel, mt_eff);
    assign link.recov_attr.mt = mt_eff;

    rmsi_issue u_issue (
        .clk       (REF_CLK),
        .rst_n     (RESETN),
        .cfg       (link.issue),
        .msi_ready (MSI_READY),
        .msi_valid (MSI_VALID),
        .msi_addr  (MSI_ADDR),
        .msi_data  (MSI_DATA),
        .msi_attr  (msi_attr)
    );

    // attribute outputs come from the sequencer's held copy
    assign MSI_NS      = msi_attr.ns;
    assign MSI_SHR     = msi_attr.shr;
    assign MSI_MEMTYPE = msi_attr.mt;
    assign REG_RDATA   = rdata_ff;
    assign REG_RDVALID = rdvalid_ff;

endmodule // rmsi_top

/* File: rtl/rmsi_cfg.svh */
// offsets, field positions, reset values and fixed codes of the msi block
`ifndef RMSI_CFG_SVH
`define RMSI_CFG_SVH

// register word offsets within the 4KB group
`define RMSI_OFF_FAULT_ADDR_LO  12'hE80
`define RMSI_OFF_FAULT_ADDR_HI  12'hE84
`define RMSI_OFF_FAULT_DATA     12'hE88
`define RMSI_OFF_RECOV_ADDR_LO  12'hE90
`define RMSI_OFF_RECOV_ADDR_HI  12'hE94
`define RMSI_OFF_RECOV_DATA     12'hE98
`define RMSI_OFF_RECOV_CTRL     12'hE9C

// control word field positions
`define RMSI_EN_BIT     7
`define RMSI_NS_BIT     6
`define RMSI_SHR_HI     5
`define RMSI_SHR_LO     4
`define RMSI_MT_HI      3
`define RMSI_MT_LO      0

// address register layout
`define RMSI_ADDR_TOP   55
`define RMSI_ADDR_LOW   2

// reset values and fixed codes
`define RMSI_EN_RESET       1'b0
`define RMSI_SHR_NONE       2'h0
`define RMSI_SHR_OUTER      2'h2
`define RMSI_SHR_INNER      2'h3
`define RMSI_MT_DEV_NGNRNE  4'h0
`define RMSI_MT_NORMAL_NC   4'h5
`define RMSI_DEV_CLASS      2'h0

`endif

/* File: rtl/rmsi_pkg.sv */
// types shared by the msi configuration block
package rmsi_pkg;

    // issue sequencer states, gray along idle -> send
    typedef enum logic [1:0] {
        RMSI_IDLE = 2'h0,
        RMSI_SEND = 2'h1
    } rmsi_state_type;

    // attributes carried with one msi write
    typedef struct packed {
        logic       ns;
        logic [1:0] shr;
        logic [3:0] mt;
    } rmsi_attr_type;

endpackage

/* File: rtl/rmsi_if.sv */
// link between register file and msi issue sequencer
`timescale 1ns/100ps

interface rmsi_if;
    import rmsi_pkg::*;

    logic          fault_evt;
    logic          recov_evt;
    logic [63:0]   fault_addr;
    logic [31:0]   fault_data;
    rmsi_attr_type fault_attr;
    logic [63:0]   recov_addr;
    logic [31:0]   recov_data;
    rmsi_attr_type recov_attr;

    modport cfg (
        output fault_evt, recov_evt, fault_addr, fault_data, fault_attr,
        output recov_addr, recov_data, recov_attr
    );
    modport issue (
        input fault_evt, recov_evt, fault_addr, fault_data, fault_attr,
        input recov_addr, recov_data, recov_attr
    );
endinterface

/* File: rtl/rmsi_issue.sv */
// msi write sequencer: holds pending events and issues one write each
`timescale 1ns/100ps

module rmsi_issue (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    rmsi_if.issue                     cfg,
    input  wire logic                 msi_ready,
    output logic                      msi_valid,
    output logic [63:0]               msi_addr,
    output logic [31:0]               msi_data,
    output rmsi_pkg::rmsi_attr_type   msi_attr
);
    import rmsi_pkg::*;

    rmsi_state_type state_ff,     nxt_state;
    logic           fault_pend_ff, nxt_fault_pend;
    logic           recov_pend_ff, nxt_recov_pend;
    logic           valid_ff,     nxt_valid;
    logic [63:0]    addr_ff,      nxt_addr;
    logic [31:0]    data_ff,      nxt_data;
    rmsi_attr_type  attr_ff,      nxt_attr;

    // a new event beats the clear of its pending flag in the same cycle
    always_comb begin
        nxt_state      = state_ff;
        nxt_valid      = valid_ff;
        nxt_addr       = addr_ff;
        nxt_data       = data_ff;
        nxt_attr       = attr_ff;
        nxt_fault_pend = fault_pend_ff | cfg.fault_evt;
        nxt_recov_pend = recov_pend_ff | cfg.recov_evt;
        case (state_ff)
            RMSI_IDLE: begin
                // fault handling wins; recovery waits one write
                if (fault_pend_ff) begin
                    nxt_addr       = cfg.fault_addr;
                    nxt_data       = cfg.fault_data;
                    nxt_attr       = cfg.fault_attr;
                    nxt_valid      = 1'b1;
                    nxt_fault_pend = cfg.fault_evt;
                    nxt_state      = RMSI_SEND;
                end else if (recov_pend_ff) begin
                    nxt_addr       = cfg.recov_addr;
                    nxt_data       = cfg.recov_data;
                    nxt_attr       = cfg.recov_attr;
                    nxt_valid      = 1'b1;
                    nxt_recov_pend = cfg.recov_evt;
                    nxt_state      = RMSI_SEND;
                end
            end
            RMSI_SEND: begin
                // hold the write stable until the interconnect takes it
                if (msi_ready) begin
                    nxt_valid = 1'b0;
                    nxt_state = RMSI_IDLE;
                end
            end
            default: begin
                nxt_valid = 1'b0;
                nxt_state = RMSI_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff      <= RMSI_IDLE;
            fault_pend_ff <= 1'b0;
            recov_pend_ff <= 1'b0;
            valid_ff      <= 1'b0;
            addr_ff       <= 64'h0;
            data_ff       <= 32'h0;
            attr_ff       <= '0;
        end else begin
            state_ff      <= nxt_state;
            fault_pend_ff <= nxt_fault_pend;
            recov_pend_ff <= nxt_recov_pend;
            valid_ff      <= nxt_valid;
            addr_ff       <= nxt_addr;
            data_ff       <= nxt_data;
            attr_ff       <= nxt_attr;
        end
    end

    assign msi_valid = valid_ff;
    assign msi_addr  = addr_ff;
    assign msi_data  = data_ff;
    assign msi_attr  = attr_ff;

endmodule // rmsi_issue

/* File: bench/rmsi_chk.sv */
// concurrent checks on the msi block's register and write ports
`timescale 1ns/100ps

module rmsi_chk #(
    parameter int PA_BITS = 48
) (
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_NS,
    input wire logic [31:0] REG_RDATA,
    input wire logic        REG_RDVALID,
    input wire logic        FAULT_IRQ,
    input wire logic        RECOVERY_IRQ,
    input wire logic        MSI_READY,
    input wire logic        MSI_VALID,
    input wire logic [63:0] MSI_ADDR,
    input wire logic [31:0] MSI_DATA,
    input wire logic        MSI_NS,
    input wire logic [1:0]  MSI_SHR,
    input wire logic [3:0]  MSI_MEMTYPE
);
    default clocking dcb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    logic en_ff;
    logic nxt_en;

    // shadow enable bit; non-secure writes must never reach it
    always_comb begin
        nxt_en = en_ff;
        if (!RESETN) begin
            nxt_en = 1'b0;
        end else if (REG_WR && REG_ADDR == 12'hE9C && !REG_NS) begin
            nxt_en = REG_WDATA[7];
        end
    end
    always_ff @(posedge REF_CLK) begin
        en_ff <= nxt_en;
    end

    rd_answer_a: assert property (REG_RD |=> REG_RDVALID)
        else $error("read not answered");
    rd_quiet_a: assert property (!REG_RDVALID |-> REG_RDATA == 32'h0)
        else $error("read data without answer");
    ctrl_read_a: assert property (REG_RD && REG_ADDR == 12'hE9C |=>
        REG_RDATA[31:8] == 24'h0 && REG_RDATA[7] == $past(en_ff))
        else $error("control word read wrong");
    addr_form_a: assert property (MSI_VALID |-> MSI_ADDR[1:0] == 2'h0 &&
        MSI_ADDR[63:56] == 8'h0 && (MSI_ADDR >> PA_BITS) == 64'h0)
        else $error("write address has reserved bits");
    msi_hold_a: assert property (MSI_VALID && !MSI_READY |=> MSI_VALID &&
        $stable({MSI_ADDR, MSI_DATA, MSI_NS, MSI_SHR, MSI_MEMTYPE}))
        else $error("offered write changed");
    msi_gap_a: assert property (MSI_VALID && MSI_READY |=> !MSI_VALID)
        else $error("no idle cycle after write");
    sh_forced_a: assert property (MSI_VALID &&
        (MSI_MEMTYPE[3:2] == 2'h0 || MSI_MEMTYPE == 4'h5) |-> MSI_SHR == 2'h2)
        else $error("shareability not forced outer");
    fault_issue_a: assert property (FAULT_IRQ |->
        ##[2:40] (MSI_VALID && MSI_READY))
        else $error("fault event gave no write");

    cover property (MSI_VALID && !MSI_READY);
    cover property (REG_RD && REG_ADDR == 12'hE9C);
    cover property (RECOVERY_IRQ && en_ff);
endmodule // rmsi_chk

bind rmsi_top rmsi_chk #(.PA_BITS(PA_BITS)) u_chk (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_NS(REG_NS), .REG_RDATA(REG_RDATA), .REG_RDVALID(REG_RDVALID),
    .FAULT_IRQ(FAULT_IRQ), .RECOVERY_IRQ(RECOVERY_IRQ),
    .MSI_READY(MSI_READY), .MSI_VALID(MSI_VALID), .MSI_ADDR(MSI_ADDR),
    .MSI_DATA(MSI_DATA), .MSI_NS(MSI_NS), .MSI_SHR(MSI_SHR),
    .MSI_MEMTYPE(MSI_MEMTYPE)
);

/* File: bench/rmsi_sink.sv */
// far side model: interconnect taking msi writes after a set stall
`timescale 1ns/100ps

module rmsi_sink (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  stall,
    input  wire logic        valid,
    input  wire logic [63:0] addr,
    input  wire logic [31:0] data,
    input  wire logic [6:0]  attr,
    output logic             ready,
    output logic [102:0]     last,
    output int               n_got
);
    logic [3:0] wait_ff;

    // ready only once the offer has waited out the stall
    assign ready = valid && (wait_ff >= stall);

    // count accepted writes so doubles or losses show up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_ff <= 4'h0;
            n_got   <= 0;
            last    <= '0;
        end else if (valid && ready) begin
            wait_ff <= 4'h0;
            n_got   <= n_got + 1;
            last    <= {addr, data, attr};
        end else if (valid) begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
endmodule // rmsi_sink

/* File: bench/ras_msi_config_tb.sv */
// self-checking bench for the msi configuration block
`timescale 1ns/100ps

`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error %0t: got %0h exp %0h", $time, g, e); \
    end \
end

module ras_msi_config_tb;
    logic         ref_clk = 1'b0;
    logic         resetn = 1'b0;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         reg_ns = 1'b0;
    logic [11:0]  reg_addr = 12'h0;
    logic [31:0]  reg_wdata = 32'h0;
    logic         fault_irq = 1'b0;
    logic         recov_irq = 1'b0;
    logic [3:0]   stall = 4'h0;
    logic [31:0]  reg_rdata, msi_data;
    logic         reg_rdvalid, msi_ready, msi_valid, msi_ns;
    logic [63:0]  msi_addr;
    logic [1:0]   msi_shr, shr, esh;
    logic [3:0]   msi_mt, mt;
    logic         ns;
    logic [102:0] last;
    logic [3:0]   codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6,
                                 4'h7, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
    int           n_got, k;
    int           mismatches = 0;
    int           n_compared = 0;

    rmsi_top u_dut (
        .REF_CLK(ref_clk), .RESETN(resetn), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_NS(reg_ns), .REG_RDATA(reg_rdata), .REG_RDVALID(reg_rdvalid),
        .FAULT_IRQ(fault_irq), .RECOVERY_IRQ(recov_irq),
        .MSI_READY(msi_ready), .MSI_VALID(msi_valid), .MSI_ADDR(msi_addr),
        .MSI_DATA(msi_data), .MSI_NS(msi_ns), .MSI_SHR(msi_shr),
        .MSI_MEMTYPE(msi_mt)
    );
    rmsi_sink u_sink (
        .clk(ref_clk), .rst_n(resetn), .stall(stall), .valid(msi_valid),
        .addr(msi_addr), .data(msi_data), .attr({msi_ns, msi_shr, msi_mt}),
        .ready(msi_ready), .last(last), .n_got(n_got)
    );

    always #50 ref_clk = ~ref_clk;

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic n);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_ns    <= n;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // answer is due exactly one edge after the request edge
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK({reg_rdvalid, reg_rdata}, {1'b1, e})
    endtask

    task automatic irq(input logic f, input logic r);
        @(posedge ref_clk);
        fault_irq <= f;
        recov_irq <= r;
        @(posedge ref_clk);
        fault_irq <= 1'b0;
        recov_irq <= 1'b0;
    endtask

    // bounded wait for the n-th accepted write, then check its content
    task automatic got(input int n, input logic [102:0] e);
        for (int i = 0; i < 60 && n_got < n; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(n_got, n)
        `CHK(last, e)
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(12'hE9C, 32'h0);
        rd(12'hE80, 32'h0);
        // low two and top address bits are never stored
        wr(12'hE80, 32'hFFFFFFFF, 1'b0);
        wr(12'hE84, 32'hFFFFFFFF, 1'b0);
        rd(12'hE80, 32'hFFFFFFFC);
        rd(12'hE84, 32'h0000FFFF);
        wr(12'hE80, 32'h12345678, 1'b0);
        wr(12'hE84, 32'h00001234, 1'b0);
        wr(12'hE88, 32'hCAFEF00D, 1'b0);
        rd(12'hE88, 32'hCAFEF00D);
        wr(12'hE8C, 32'hFFFFFFFF, 1'b0);
        rd(12'hE8C, 32'h0);
        // fault write: fixed attributes, device type forces outer
        stall <= 4'h3;
        irq(1'b1, 1'b0);
        got(1, {64'h1234_12345678, 32'hCAFEF00D, 7'h20});
        wr(12'hE90, 32'h0000ABC0, 1'b0);
        wr(12'hE98, 32'h5A5A5A5A, 1'b0);
        // a disabled recovery event is dropped
        irq(1'b0, 1'b1);
        repeat (10) @(posedge ref_clk);
        `CHK(n_got, 1)
        wr(12'hE9C, 32'h000000FF, 1'b1);
        rd(12'hE9C, 32'h0);
        // every valid memory type once, cycling the three shareabilities and both spaces
        for (k = 0; k < 13; k++) begin
            mt = codes[k];
            shr = (k % 3 == 0) ? 2'h0 : ((k % 3 == 1) ? 2'h2 : 2'h3);
            ns = k[0];
            stall <= 4'(k % 4);
            esh = (mt[3:2] == 2'h0 || mt == 4'h5) ? 2'h2 : shr;
            wr(12'hE9C, {24'hFFFFFF, 1'b1, ns, shr, mt}, 1'b0);
            rd(12'hE9C, {24'h0, 1'b1, ns, shr, mt});
            irq(1'b0, 1'b1);
            got(2 + k, {64'hABC0, 32'h5A5A5A5A, ns, esh, mt});
        end
        // simultaneous events: fault first, then recovery
        irq(1'b1, 1'b1);
        got(15, {64'h1234_12345678, 32'hCAFEF00D, 7'h20});
        got(16, {64'hABC0, 32'h5A5A5A5A, 7'h0F});
        // a second reset clears the enable again
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(12'hE9C, 32'h0);
        irq(1'b0, 1'b1);
        repeat (10) @(posedge ref_clk);
        `CHK(n_got, 0)
        give_verdict();
    end
endmodule // ras_msi_config_tb
